// >>> core/dcs_device.sv
/*
 * Device end of the DAC channel-select port: serial framing, parallel
 * channel select, channel register file and acquisition timing.
 * Assumes link pins are synchronous to clock_in and the host clock is
 * at least four clock_in periods per half cycle.
 */
// Our own choices: the address map and the strobed register port.
// Overview of operation
// - Chip select active low, shared with frame sync
// - Capture address on write strobe rising edge
// - Five address bits pick one of 32
// - Offset select overrides channel address
// - All-channel acquire: every channel, longer time
// - Drive on rising, sample on falling clock
// - Words travel most significant bit first
// - Readback ignores input; data centred in 16
// - Host uses 10, 3x8, 16 bit words
// - Host left-justifies 10-bit command in bytes
// - Host raises frame sync between transfers
// - Byte host sends two or three bytes
// - Host data valid at falling edge
// - Opposite-sense host clock must be inverted
// - Host frames every word active low
// - Parallel port only when interface select low
// - Frame sync clears counter; extra edges ignored
// - Output driven from first rise to fourteenth fall
// - First two bits choose operating mode
`timescale 1ns/100ps
module dcs_device
    import dcs_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    dcs_link_if.device link,
    output logic acq_start_out,
    output logic acq_all_out,
    output logic acq_offset_out,
    output logic [4:0] acq_channel_out,
    output logic acq_busy_out,
    output logic dac_write_out,
    output logic [5:0] dac_index_out,
    output logic [13:0] dac_data_out
);

    typedef enum {
        DCS_IDLE,
        DCS_SHIFT_IN,
        DCS_SHIFT_OUT
    } dcs_dev_state_t;

    dcs_dev_state_t state_reg;
    logic sync_prev_reg;
    logic sclk_prev_reg;
    logic wr_prev_reg;
    logic [4:0] bit_cnt_reg;
    logic [22:0] in_sr_reg;
    logic [1:0] mode_reg;
    logic rb_pending_reg;
    logic [5:0] rb_index_reg;
    logic [13:0] rb_sr_reg;
    logic dout_reg;
    logic oe_n_reg;
    logic [11:0] acq_cnt_reg;
    logic [13:0] dac_mem [0:CHANNELS];

    logic serial_en;
    logic par_en;
    logic sync_fall;
    logic sclk_rise;
    logic sclk_fall;
    logic in_last;
    logic word_done;
    logic [23:0] word;
    logic [9:0] cmd;
    logic par_write;
    logic ser_acq;

    // Channel index: offset channel sits above the 32 outputs
    function automatic logic [5:0] chan_index(input logic offs,
                                              input logic [4:0] addr);
        chan_index = offs ? 6'(OFFS_INDEX) : {1'h0, addr};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Edge detection on the link pins

    assign serial_en = link.interface_select;
    assign par_en = ~link.interface_select;
    assign sync_fall = sync_prev_reg & ~link.sync_cs_n;
    assign sclk_rise = ~sclk_prev_reg & link.sclk;
    assign sclk_fall = sclk_prev_reg & ~link.sclk;
    assign par_write = par_en & ~wr_prev_reg & link.wr_n
                       & ~link.sync_cs_n;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_prev_reg <= 1'h1;
            sclk_prev_reg <= 1'h0;
            wr_prev_reg <= 1'h1;
        end else begin
            sync_prev_reg <= link.sync_cs_n;
            sclk_prev_reg <= link.sclk;
            wr_prev_reg <= link.wr_n;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Serial framing

    // A DAC write is 24 bits, every other command word 10
    assign in_last = (mode_reg == MODE_DAC && bit_cnt_reg >= 5'h02)
                     ? (bit_cnt_reg == 5'(DAC_BITS - 1))
                     : (bit_cnt_reg == 5'(CMD_BITS - 1));
    assign word = {in_sr_reg, link.din};
    assign word_done = (state_reg == DCS_SHIFT_IN) & sclk_fall & in_last;
    assign cmd = (mode_reg == MODE_DAC) ? word[23:14] : word[9:0];
    assign ser_acq = word_done & (cmd[F_MODE_HI:F_MODE_LO] == MODE_ACQ
        || cmd[F_MODE_HI:F_MODE_LO] == MODE_ACQ_RB);

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= DCS_IDLE;
        end else if (!serial_en) begin
            state_reg <= DCS_IDLE;
        end else begin
            unique case (state_reg)
                DCS_IDLE: begin
                    if (sync_fall) begin
                        state_reg <= rb_pending_reg ? DCS_SHIFT_OUT
                                                    : DCS_SHIFT_IN;
                    end
                end
                DCS_SHIFT_IN: begin
                    if (word_done) begin
                        state_reg <= DCS_IDLE;
                    end
                end
                DCS_SHIFT_OUT: begin
                    if (sclk_fall
                        && bit_cnt_reg == 5'(DATA_BITS - 1)) begin
                        state_reg <= DCS_IDLE;
                    end
                end
            endcase
        end
    end

    // Sync edges inside a frame are ignored by the state machine
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_cnt_reg <= 5'h00;
        end else if (state_reg == DCS_IDLE && sync_fall) begin
            bit_cnt_reg <= 5'h00;
        end else if (state_reg != DCS_IDLE && sclk_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            in_sr_reg <= 23'h000000;
            mode_reg <= MODE_ACQ;
        end else if (state_reg == DCS_SHIFT_IN && sclk_fall) begin
            in_sr_reg <= word[22:0];
            if (bit_cnt_reg == 5'h01) begin
                mode_reg <= {in_sr_reg[0], link.din};
            end
        end else if (state_reg == DCS_IDLE && sync_fall) begin
            mode_reg <= MODE_ACQ;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Readback

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rb_pending_reg <= 1'h0;
            rb_index_reg <= 6'h00;
        end else if (!serial_en) begin
            rb_pending_reg <= 1'h0;
        end else if (word_done && cmd[F_MODE_HI]) begin
            rb_pending_reg <= 1'h1;
            rb_index_reg <= chan_index(cmd[F_OFFS],
                                       cmd[F_ADDR_HI:0]);
        end else if (state_reg == DCS_IDLE && sync_fall) begin
            rb_pending_reg <= 1'h0;
        end
    end

    // Input line is not looked at while shifting out
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rb_sr_reg <= 14'h0000;
            dout_reg <= 1'h0;
            oe_n_reg <= 1'h1;
        end else if (state_reg == DCS_IDLE) begin
            oe_n_reg <= 1'h1;
            if (sync_fall && rb_pending_reg) begin
                rb_sr_reg <= dac_mem[rb_index_reg];
            end
        end else if (state_reg == DCS_SHIFT_OUT) begin
            if (sclk_rise) begin
                dout_reg <= rb_sr_reg[13];
                rb_sr_reg <= {rb_sr_reg[12:0], 1'h0};
                oe_n_reg <= 1'h0;
            end else if (sclk_fall
                         && bit_cnt_reg == 5'(DATA_BITS - 1)) begin
                oe_n_reg <= 1'h1;
            end
        end
    end

    assign link.dout = dout_reg;
    assign link.dout_oe_n = oe_n_reg;

    ////////////////////////////////////////////////////////////////////
    // Channel registers

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i <= CHANNELS; i++) begin
                dac_mem[i] <= 14'h0000;
            end
        end else if (word_done && mode_reg == MODE_DAC) begin
            if (cmd[F_CAL]) begin
                // Test load to every output
                for (int i = 0; i < CHANNELS; i++) begin
                    dac_mem[i] <= word[13:0];
                end
            end else begin
                dac_mem[chan_index(cmd[F_OFFS], cmd[F_ADDR_HI:0])]
                    <= word[13:0];
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dac_write_out <= 1'h0;
            dac_index_out <= 6'h00;
            dac_data_out <= 14'h0000;
        end else begin
            dac_write_out <= word_done && mode_reg == MODE_DAC;
            if (word_done && mode_reg == MODE_DAC) begin
                dac_index_out <= chan_index(cmd[F_OFFS],
                                            cmd[F_ADDR_HI:0]);
                dac_data_out <= word[13:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Acquisition

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acq_start_out <= 1'h0;
            acq_all_out <= 1'h0;
            acq_offset_out <= 1'h0;
            acq_channel_out <= 5'h00;
        end else begin
            acq_start_out <= par_write | ser_acq;
            if (par_write) begin
                acq_all_out <= link.all_acquire;
                acq_offset_out <= link.offset_sel;
                acq_channel_out <= link.channel_addr;
            end else if (ser_acq) begin
                acq_all_out <= cmd[F_CAL];
                acq_offset_out <= cmd[F_OFFS];
                acq_channel_out <= cmd[F_ADDR_HI:0];
            end
        end
    end

    // Busy covers the acquisition time; a new request restarts it
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acq_cnt_reg <= 12'h000;
            acq_busy_out <= 1'h0;
        end else if (acq_start_out) begin
            acq_cnt_reg <= acq_all_out ? ACQ_ALL_CYC - 12'h001
                                       : ACQ_ONE_CYC - 12'h001;
            acq_busy_out <= 1'h1;
        end else if (acq_cnt_reg != 12'h000) begin
            acq_cnt_reg <= acq_cnt_reg - 12'h001;
        end else begin
            acq_busy_out <= 1'h0;
        end
    end

endmodule // dcs_device

// >>> inc/dcs_pkg.sv
/*
 * Shared constants for the DAC channel-select link: serial word layout,
 * mode codes, frame lengths and timing counts.
 * Assumes a single 50 MHz clock on both ends.
 */
package dcs_pkg;
    localparam int CLK_PERIOD_NS = 20;
    // Command word fields, in shift order from the first bit
    localparam int CMD_BITS = 10;
    localparam int DAC_BITS = 24;
    localparam int DATA_BITS = 14;
    localparam int RB_HOST_BITS = 16;
    localparam int F_MODE_HI = 9;
    localparam int F_MODE_LO = 8;
    localparam int F_CAL = 7;
    localparam int F_OFFS = 6;
    localparam int F_TEST = 5;
    localparam int F_ADDR_HI = 4;
    localparam int CHANNELS = 32;
    localparam int OFFS_INDEX = 32;
    localparam logic [1:0] MODE_ACQ = 2'h0;
    localparam logic [1:0] MODE_DAC = 2'h1;
    localparam logic [1:0] MODE_ACQ_RB = 2'h2;
    localparam logic [1:0] MODE_RB = 2'h3;
    // Acquisition times
    localparam int ACQ_ONE_NS = 16000;
    localparam int ACQ_ALL_NS = 45000;
    localparam logic [11:0] ACQ_ONE_CYC =
        12'((ACQ_ONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] ACQ_ALL_CYC =
        12'((ACQ_ALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Host timing
    localparam int SCLK_HALF_NS = 80;
    localparam int FRAME_GAP_NS = 400;
    localparam int WR_LOW_NS = 60;
    localparam logic [4:0] SCLK_HALF_CYC =
        5'(SCLK_HALF_NS / CLK_PERIOD_NS);
    localparam logic [4:0] GAP_CYC =
        5'((FRAME_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] WR_LOW_CYC =
        5'((WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Host register map
    localparam logic [7:0] REG_TX = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_RX = 8'h0C;
    localparam logic [7:0] REG_PAR = 8'h10;
    localparam logic [7:0] REG_SEL = 8'h14;
    localparam logic [1:0] KIND_CMD = 2'h0;
    localparam logic [1:0] KIND_DAC = 2'h1;
    localparam logic [1:0] KIND_READ = 2'h2;
    localparam int P_OFFS = 5;
    localparam int P_CAL = 6;
    localparam logic SEL_RESET = 1'h1;
endpackage

// >>> inc/dcs_link_if.sv
/*
 * Pins between the host port and the DAC channel-select device.
 * Both ends run on the same clock; the readback line is resolved here.
 */
`timescale 1ns/100ps
interface dcs_link_if;
    logic sync_cs_n;
    logic sclk;
    logic din;
    logic dout;
    logic dout_oe_n;
    logic dout_line;
    logic interface_select;
    logic wr_n;
    logic [4:0] channel_addr;
    logic offset_sel;
    logic all_acquire;

    // Released line reads low
    assign dout_line = ~dout_oe_n & dout;

    modport device (
        input sync_cs_n, sclk, din, interface_select, wr_n,
        input channel_addr, offset_sel, all_acquire,
        output dout, dout_oe_n
    );
    modport host (
        output sync_cs_n, sclk, din, interface_select, wr_n,
        output channel_addr, offset_sel, all_acquire,
        input dout_line
    );
endinterface

// >>> core/dcs_host.sv
/*
 * Host end of the DAC channel-select port: a register-driven serial
 * framer and parallel strobe generator.
 * Assumes software waits for the busy bit before starting a transfer.
 */
`timescale 1ns/100ps
module dcs_host
    import dcs_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    dcs_link_if.host link,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out
);

    typedef enum {
        DCS_H_IDLE,
        DCS_H_LEAD,
        DCS_H_SHIFT,
        DCS_H_TAIL,
        DCS_H_GAP,
        DCS_H_WR_LOW,
        DCS_H_WR_HOLD
    } dcs_host_state_t;

    dcs_host_state_t state_reg;
    logic [23:0] tx_word_reg;
    logic [23:0] tx_sr_reg;
    logic [15:0] rx_sr_reg;
    logic rx_bit_reg;
    logic [4:0] tmr_reg;
    logic [4:0] bit_reg;
    logic [4:0] last_reg;
    logic sync_reg;
    logic sclk_reg;
    logic din_reg;
    logic wr_n_reg;
    logic sel_reg;
    logic [6:0] par_reg;
    logic busy;
    logic start_frame;
    logic start_par;

    function automatic logic [4:0] kind_last(input logic [1:0] kind);
        unique case (kind)
            KIND_DAC: kind_last = 5'(DAC_BITS - 1);
            KIND_READ: kind_last = 5'(RB_HOST_BITS - 1);
            default: kind_last = 5'(CMD_BITS - 1);
        endcase
    endfunction

    assign busy = state_reg != DCS_H_IDLE;
    assign start_frame = wr_in & addr_in == REG_CTRL & ~busy & sel_reg
                         & wdata_in[1:0] != 2'h3;
    assign start_par = wr_in & addr_in == REG_PAR & ~busy & ~sel_reg;

    ////////////////////////////////////////////////////////////////////
    // Register port

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_word_reg <= 24'h000000;
            sel_reg <= SEL_RESET;
            rdata_out <= 32'h00000000;
        end else begin
            if (wr_in && addr_in == REG_TX) begin
                // 10-bit commands sit left-justified in bits 23:14
                tx_word_reg <= wdata_in[23:0];
            end
            if (wr_in && addr_in == REG_SEL && !busy) begin
                sel_reg <= wdata_in[0];
            end
            rdata_out <= 32'h00000000;
            if (rd_in) begin
                unique case (addr_in)
                    REG_TX: rdata_out <= {8'h00, tx_word_reg};
                    REG_STATUS: rdata_out <= {31'h0, busy};
                    REG_RX: rdata_out <= {16'h0000, rx_sr_reg};
                    REG_PAR: rdata_out <= {25'h0, par_reg};
                    REG_SEL: rdata_out <= {31'h0, sel_reg};
                    default: rdata_out <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Link sequencer

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= DCS_H_IDLE;
            tmr_reg <= 5'h00;
            bit_reg <= 5'h00;
            last_reg <= 5'h00;
            tx_sr_reg <= 24'h000000;
            rx_sr_reg <= 16'h0000;
            rx_bit_reg <= 1'h0;
            sync_reg <= 1'h1;
            sclk_reg <= 1'h0;
            din_reg <= 1'h0;
            wr_n_reg <= 1'h1;
            par_reg <= 7'h00;
        end else if (state_reg != DCS_H_IDLE && tmr_reg != 5'h00) begin
            tmr_reg <= tmr_reg - 5'h01;
        end else begin
            unique case (state_reg)
                DCS_H_IDLE: begin
                    tmr_reg <= SCLK_HALF_CYC - 5'h01;
                    if (start_frame) begin
                        sync_reg <= 1'h0;
                        tx_sr_reg <= tx_word_reg;
                        last_reg <= kind_last(wdata_in[1:0]);
                        rx_bit_reg <= 1'h0;
                        bit_reg <= 5'h00;
                        state_reg <= DCS_H_LEAD;
                    end else if (start_par) begin
                        par_reg <= wdata_in[6:0];
                        sync_reg <= 1'h0;
                        wr_n_reg <= 1'h0;
                        tmr_reg <= WR_LOW_CYC - 5'h01;
                        state_reg <= DCS_H_WR_LOW;
                    end
                end
                DCS_H_LEAD, DCS_H_SHIFT: begin
                    tmr_reg <= SCLK_HALF_CYC - 5'h01;
                    state_reg <= DCS_H_SHIFT;
                    if (!sclk_reg) begin
                        // Clock idles low; data changes on the rise
                        sclk_reg <= 1'h1;
                        din_reg <= tx_sr_reg[23];
                        tx_sr_reg <= {tx_sr_reg[22:0], 1'h0};
                        rx_sr_reg <= {rx_sr_reg[14:0],
                                      rx_bit_reg};
                    end else begin
                        // Last bit is released at this fall, so take
                        // it here and shift it in on the next rise
                        rx_bit_reg <= link.dout_line;
                        sclk_reg <= 1'h0;
                        bit_reg <= bit_reg + 5'h01;
                        if (bit_reg == last_reg) begin
                            state_reg <= DCS_H_TAIL;
                        end
                    end
                end
                DCS_H_TAIL: begin
                    sync_reg <= 1'h1;
                    tmr_reg <= GAP_CYC - 5'h01;
                    state_reg <= DCS_H_GAP;
                end
                DCS_H_WR_LOW: begin
                    wr_n_reg <= 1'h1;
                    tmr_reg <= WR_LOW_CYC - 5'h01;
                    state_reg <= DCS_H_WR_HOLD;
                end
                DCS_H_WR_HOLD: begin
                    sync_reg <= 1'h1;
                    tmr_reg <= GAP_CYC - 5'h01;
                    state_reg <= DCS_H_GAP;
                end
                DCS_H_GAP: begin
                    state_reg <= DCS_H_IDLE;
                end
            endcase
        end
    end

    assign link.sync_cs_n = sync_reg;
    assign link.sclk = sclk_reg;
    assign link.din = din_reg;
    assign link.wr_n = wr_n_reg;
    assign link.interface_select = sel_reg;
    assign link.channel_addr = par_reg[4:0];
    assign link.offset_sel = par_reg[P_OFFS];
    assign link.all_acquire = par_reg[P_CAL];

endmodule // dcs_host

// >>> verification/dcs_link_asserts.sv
/* Checker for the pins between the host and device ends.
   Takes the link interface signals as plain inputs; one clock domain. */
`timescale 1ns/100ps
module dcs_link_asserts (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic sync_cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe_n,
    input wire logic interface_select,
    input wire logic wr_n
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////////////
    // Device answers at the edge after it first sees a clock edge
    sequence rise_1ago;
        $past(sclk) && !$past(sclk, 2);
    endsequence
    sequence fall_1ago;
        !$past(sclk) && $past(sclk, 2);
    endsequence
    sequence wr_pulse;
        !wr_n [*3] ##1 wr_n;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    oe_serial_only_a: assert property (!interface_select |-> dout_oe_n)
        else $error("readback driven in parallel mode");
    oe_frame_only_a: assert property (sync_cs_n && $past(sync_cs_n) |-> dout_oe_n)
        else $error("readback driven outside a frame");
    oe_on_rise_a: assert property ($fell(dout_oe_n) |-> rise_1ago)
        else $error("readback enabled off a rising clock");
    oe_off_fall_a: assert property ($rose(dout_oe_n) |-> fall_1ago)
        else $error("readback released off a falling clock");
    dout_on_rise_a: assert property (!dout_oe_n && $changed(dout) |-> rise_1ago)
        else $error("readback bit changed off a rising clock");
    clock_idle_a: assert property (sync_cs_n |-> !sclk)
        else $error("serial clock high outside a frame");
    din_hold_a: assert property ($fell(sclk) |-> $stable(din))
        else $error("serial data moved at the falling clock");
    wr_framed_a: assert property (!wr_n |-> !sync_cs_n && !interface_select)
        else $error("write strobe outside a parallel frame");
    wr_width_a: assert property ($fell(wr_n) |-> wr_pulse)
        else $error("write strobe width wrong");
    frame_gap_a: assert property ($rose(sync_cs_n) |-> sync_cs_n [*8])
        else $error("frame sync not held high between frames");
    first_clock_a: assert property ($fell(sync_cs_n) && interface_select |-> !sclk [*4] ##1 sclk)
        else $error("first serial clock misplaced");
endmodule // dcs_link_asserts

// >>> verification/dac_channel_select_host_port_tb.sv
/* Bench for the host and device ends joined by the link interface.
   Drives the host register port; watches the device user side. */
`timescale 1ns/100ps
module dac_channel_select_host_port_tb
    import dcs_pkg::*;
;
    logic clock_in, rst_n_in, wr_in, rd_in, chk;
    logic rd_d = 1'b0;
    logic chk_d = 1'b0;
    logic [7:0] addr_in;
    logic [31:0] wdata_in, rdata_out, rs, v, e;
    logic acq_start, acq_all, acq_offs, acq_busy, dac_wr;
    logic [4:0] acq_ch;
    logic [5:0] dac_idx;
    logic [13:0] dac_data;
    logic [31:0] q_acq[$], q_dac[$], q_rd[$], q_msk[$];
    int fails, n_checks, bcnt;
    logic [31:0] eb;
    dcs_link_if lnk ();
    dcs_host i_dcs_host (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .link(lnk), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out));
    dcs_device i_dcs_device (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .link(lnk), .acq_start_out(acq_start), .acq_all_out(acq_all),
        .acq_offset_out(acq_offs), .acq_channel_out(acq_ch),
        .acq_busy_out(acq_busy), .dac_write_out(dac_wr),
        .dac_index_out(dac_idx), .dac_data_out(dac_data));
    dcs_link_asserts i_dcs_link_asserts (.clock_in(clock_in),
        .rst_n_in(rst_n_in), .sync_cs_n(lnk.sync_cs_n), .sclk(lnk.sclk),
        .din(lnk.din), .dout(lnk.dout), .dout_oe_n(lnk.dout_oe_n),
        .interface_select(lnk.interface_select), .wr_n(lnk.wr_n));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic c);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        chk <= c;
        @(posedge clock_in);
        rd_in <= 1'b0;
        @(negedge clock_in);
        v = rdata_out;
    endtask
    task automatic exp_rd(input logic [7:0] a, input logic [31:0] x, m);
        q_rd.push_back(x);
        q_msk.push_back(m);
        rd(a, 1'b1);
    endtask
    // Polls the host busy bit; a stuck host counts as a mismatch
    task automatic idle();
        for (int i = 0; i < 200; i++) begin
            rd(REG_STATUS, 1'b0);
            if (v[0] === 1'b0) return;
        end
        fails++;
    endtask
    task automatic acq_idle();
        for (int i = 0; i < 3000 && acq_busy !== 1'b0; i++) @(posedge clock_in);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Every result must match the oldest note; a result with none fails
    always @(posedge clock_in) begin
        if (acq_start === 1'b1) begin
            e = q_acq.size() ? q_acq.pop_front() : '1;
            check(32'({acq_all, acq_offs, acq_ch}), e);
            eb = acq_all ? 32'(ACQ_ALL_CYC) : 32'(ACQ_ONE_CYC);
        end
        // Busy must last exactly the acquisition time of the request
        if (acq_busy === 1'b1) begin
            bcnt++;
        end else if (bcnt != 0) begin
            check(32'(bcnt), eb);
            bcnt = 0;
        end
        if (dac_wr === 1'b1) begin
            e = q_dac.size() ? q_dac.pop_front() : '1;
            check(32'({dac_idx, dac_data}), e);
        end
        if (rd_d && chk_d)
            check(rdata_out & q_msk.pop_front(), q_rd.pop_front());
        rd_d <= rd_in;
        chk_d <= chk;
    end
    initial begin
        clock_in = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clock_in = ~clock_in;
    end
    initial begin
        #(CLK_PERIOD_NS * 40000);
        fails++;
        end_of_test();
    end
    initial begin
        logic [4:0] a;
        logic [13:0] d;
        logic o, l;
        logic [1:0] m;
        rs = 32'h5E48983A;
        {rst_n_in, wr_in, rd_in, chk, addr_in, wdata_in} = '0;
        repeat (12) @(posedge clock_in);
        rst_n_in <= 1'b1;
        exp_rd(REG_SEL, 32'h1, '1);
        exp_rd(REG_STATUS, 32'h0, '1);
        exp_rd(8'h1C, 32'h0, '1);
        wr(REG_PAR, 32'h1F);
        for (int k = 0; k < 4; k++) begin
            a = 5'(rnd());
            d = 14'(rnd());
            o = (k == 3);
            m = k[0] ? MODE_RB : MODE_ACQ_RB;
            q_dac.push_back(32'({o ? 6'h20 : {1'b0, a}, d}));
            wr(REG_TX, {8'h0, MODE_DAC, 1'b0, o, 1'b0, a, d});
            wr(REG_CTRL, 32'(KIND_DAC));
            idle();
            if (m == MODE_ACQ_RB) q_acq.push_back(32'({1'b0, o, o ? 5'h0 : a}));
            wr(REG_TX, {8'h0, m, 1'b0, o, 1'b0, o ? 5'h0 : a, 14'h0});
            wr(REG_CTRL, 32'(KIND_CMD));
            idle();
            acq_idle();
            wr(REG_CTRL, 32'(KIND_READ));
            idle();
            exp_rd(REG_RX, 32'({d, 1'b0}), 32'h7FFE);
        end
        q_acq.push_back(32'h40);
        wr(REG_TX, {8'h0, MODE_ACQ, 1'b1, 21'h0});
        wr(REG_CTRL, 32'(KIND_CMD));
        idle();
        acq_idle();
        wr(REG_SEL, 32'h0);
        wr(REG_CTRL, 32'(KIND_CMD));
        idle();
        for (int j = 0; j < 3; j++) begin
            o = (j == 1);
            l = (j == 2);
            a = (j == 0) ? 5'(rnd()) : 5'h0;
            q_acq.push_back(32'({l, o, a}));
            wr(REG_PAR, 32'({l, o, a}));
            idle();
            acq_idle();
        end
        repeat (50) @(posedge clock_in);
        end_of_test();
    end
endmodule // dac_channel_select_host_port_tb
